// File: hw/flash_link_pkg.sv
package flash_link_pkg;
   // command/address phase length, one byte per link clock
   localparam int CA_BYTES = 6;
   // initial read latency in link clocks
   localparam int READ_LATENCY = 6;
   localparam int FIFO_DEPTH = 16;
   // bytes in one word; a non-burst write keeps one word
   localparam int WORD_BYTES = 2;
   // fields of the first command/address byte, then the write byte count limit
   localparam int RW_BIT = 7;
   localparam int BURST_TYPE_BIT = 5;
   localparam logic RW_READ = 1'b1;
   localparam logic BURST_LINEAR = 1'b1;
   localparam logic [3:0] CNT_MAX = 4'hf;

   typedef enum logic [1:0] {
      ST_CA = 2'b00,
      ST_LAT = 2'b01,
      ST_XFER = 2'b11
   } link_state_e;

   typedef struct packed {
      logic is_cmd;
      logic [7:0] data;
   } link_byte_s;
endpackage

// File: hw/flash_link_slave.sv
`timescale 1ns/1ps

module async_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // filling side
   input wire logic wr_clk,
   input wire logic wr_rst_n,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [WIDTH-1:0] wr_data,
   // draining side
   input wire logic rd_clk,
   input wire logic rd_rst_n,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [WIDTH-1:0] rd_data
);
   localparam int AW = $clog2(DEPTH);

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      to_gray = (b >> 1) ^ b;
   endfunction

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wbin, wgray, rgray_m, rgray_s;
   logic [AW:0] rbin, rgray, wgray_m, wgray_s;
   logic [AW:0] next_wbin, next_wgray, next_rbin, next_rgray;
   logic full, empty, next_full, next_empty, push, pop;

   // full and empty are computed from next pointers so the flags stay exact
   always_comb begin
      push = wr_valid && !full;
      next_wbin = wbin + (AW + 1)'(push);
      next_wgray = to_gray(next_wbin);
      next_full = next_wgray == {~rgray_s[AW:AW-1], rgray_s[AW-2:0]};
   end

   always_ff @(posedge wr_clk or negedge wr_rst_n) begin
      if (!wr_rst_n) begin
         wbin <= '0;
         wgray <= '0;
         rgray_m <= '0;
         rgray_s <= '0;
         full <= 1'b0;
      end else begin
         wbin <= next_wbin;
         wgray <= next_wgray;
         rgray_m <= rgray;
         rgray_s <= rgray_m;
         full <= next_full;
      end
   end

   always_ff @(posedge wr_clk) begin
      if (push) begin
         mem[wbin[AW-1:0]] <= wr_data;
      end
   end

   always_comb begin
      pop = rd_ready && !empty;
      next_rbin = rbin + (AW + 1)'(pop);
      next_rgray = to_gray(next_rbin);
      next_empty = next_rgray == wgray_s;
   end

   always_ff @(posedge rd_clk or negedge rd_rst_n) begin
      if (!rd_rst_n) begin
         rbin <= '0;
         rgray <= '0;
         wgray_m <= '0;
         wgray_s <= '0;
         empty <= 1'b1;
      end else begin
         rbin <= next_rbin;
         rgray <= next_rgray;
         wgray_m <= wgray;
         wgray_s <= wgray_m;
         empty <= next_empty;
      end
   end

   assign wr_ready = !full;
   assign rd_valid = !empty;
   assign rd_data = mem[rbin[AW-1:0]];
endmodule

module flash_link_slave
   import flash_link_pkg::*;
#(
   parameter bit LOW_VOLTAGE = 1'b0
) (
   // system
   input wire logic sys_clk,
   input wire logic rst_n,
   // bus pins
   input wire logic ck,
   input wire logic ck_n,
   input wire logic delayed_host_clock,
   input wire logic delayed_host_clock_n,
   input wire logic cs_n,
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out,
   output logic dq_oe,
   input wire logic rwds_in,
   output logic rwds_out,
   output logic rwds_oe,
   input wire logic phase_shifted_strobe_mode,
   // bytes received from the host
   output link_byte_s host_byte,
   output logic host_valid,
   input wire logic host_ready,
   // read data toward the host
   input wire logic [7:0] rd_byte,
   input wire logic rd_valid,
   output logic rd_ready,
   // array state and events
   input wire logic word_program,
   input wire logic address_space_overlay,
   output logic drop_pulse
);
   logic link_clk, psc_clk, strobe_clk, link_clr;
   link_state_e state, next_state;
   logic [3:0] cnt, next_cnt;
   logic is_read, next_is_read, is_linear, next_is_linear;
   logic [7:0] next_dq_out;
   logic next_dq_oe, next_rwds_oe, rwds_tog, next_rwds_tog;
   logic drop_tog, next_drop_tog, keep, refused;
   logic burst_ok, next_burst_ok, ok_meta, ok_s, burst_ok_s;
   logic sel_fresh;
   logic drop_meta, drop_s, drop_old, next_drop_pulse;
   link_byte_s wf_data, hf_data, next_host_byte;
   logic wf_valid, wf_ready, hf_valid, hf_ready, next_host_valid;
   logic [7:0] rf_data;
   logic rf_valid, rf_ready, rd_pop;

   // the true clock alone unless the differential receiver is fitted
   generate
      if (LOW_VOLTAGE) begin : g_diff
         assign link_clk = ck & ~ck_n;
         assign psc_clk = delayed_host_clock & ~delayed_host_clock_n;
      end else begin : g_single
         assign link_clk = ck;
         assign psc_clk = delayed_host_clock;
      end
   endgenerate

   // strap pin; normal mode centres the strobe half a clock after data
   assign strobe_clk = phase_shifted_strobe_mode ? psc_clk : ~link_clk;
   // raising select clears the link logic at once, no clock needed
   assign link_clr = cs_n | ~rst_n;

   async_fifo #(.WIDTH($bits(link_byte_s)), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
      .wr_clk(link_clk),
      .wr_rst_n(rst_n),
      .wr_valid(wf_valid),
      .wr_ready(wf_ready),
      .wr_data(wf_data),
      .rd_clk(sys_clk),
      .rd_rst_n(rst_n),
      .rd_valid(hf_valid),
      .rd_ready(hf_ready),
      .rd_data(hf_data)
   );

   async_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
      .wr_clk(sys_clk),
      .wr_rst_n(rst_n),
      .wr_valid(rd_valid),
      .wr_ready(rd_ready),
      .wr_data(rd_byte),
      .rd_clk(link_clk),
      .rd_rst_n(rst_n),
      .rd_valid(rf_valid),
      .rd_ready(rf_ready),
      .rd_data(rf_data)
   );

   // link side: bytes taken on each rising link clock
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_is_read = is_read;
      next_is_linear = is_linear;
      next_dq_out = dq_out;
      next_dq_oe = dq_oe;
      next_rwds_oe = 1'b1;
      next_rwds_tog = rwds_tog;
      wf_valid = 1'b0;
      wf_data = '{is_cmd: (state == ST_CA), data: dq_in};
      rf_ready = 1'b0;
      keep = 1'b1;
      case (state)
         ST_CA: begin
            wf_valid = 1'b1;
            next_cnt = cnt + 4'h1;
            if (cnt == 4'h0) begin
               next_is_read = dq_in[RW_BIT] == RW_READ;
               next_is_linear = dq_in[BURST_TYPE_BIT] == BURST_LINEAR;
            end
            if (cnt == 4'(CA_BYTES - 1)) begin
               next_cnt = 4'h0;
               next_state = is_read ? ST_LAT : ST_XFER;
            end
         end
         ST_LAT: begin
            next_dq_oe = 1'b1;
            next_cnt = cnt + 4'h1;
            if (cnt == 4'(READ_LATENCY - 1)) begin
               next_cnt = 4'h0;
               next_state = ST_XFER;
            end
         end
         ST_XFER: begin
            if (is_read) begin
               rf_ready = 1'b1;
               if (rf_valid) begin
                  next_dq_out = rf_data;
                  next_rwds_tog = ~rwds_tog;
               end
            end else begin
               if (cnt != CNT_MAX) begin
                  next_cnt = cnt + 4'h1;
               end
               // linear bursts only; one word unless a program load outside overlay
               keep = is_linear
                  && (cnt < 4'(WORD_BYTES) || burst_ok_s);
               wf_valid = keep;
            end
         end
         default: begin
            next_state = ST_CA;
         end
      endcase
      // clock edges while deselected must not push bytes
      if (link_clr) begin
         wf_valid = 1'b0;
         keep = 1'b1;
      end
      refused = !keep || (wf_valid && !wf_ready);
      next_drop_tog = refused ? ~drop_tog : drop_tog;
   end

   always_ff @(posedge link_clk or posedge link_clr) begin
      if (link_clr) begin
         state <= ST_CA;
         cnt <= 4'h0;
         is_read <= 1'b0;
         is_linear <= 1'b0;
         dq_out <= 8'h00;
         dq_oe <= 1'b0;
         rwds_oe <= 1'b0;
         rwds_tog <= 1'b0;
         sel_fresh <= 1'b1;
      end else begin
         sel_fresh <= 1'b0;
         state <= next_state;
         cnt <= next_cnt;
         is_read <= next_is_read;
         is_linear <= next_is_linear;
         dq_out <= next_dq_out;
         dq_oe <= next_dq_oe;
         rwds_oe <= next_rwds_oe;
         rwds_tog <= next_rwds_tog;
      end
   end

   // write transactions never toggle, so the strobe stays low
   always_ff @(posedge strobe_clk or posedge link_clr) begin
      if (link_clr) begin
         rwds_out <= 1'b0;
      end else begin
         rwds_out <= rwds_tog;
      end
   end

   // kept over deselect so an event is never lost
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         drop_tog <= 1'b0;
         ok_meta <= 1'b0;
         ok_s <= 1'b0;
      end else begin
         drop_tog <= next_drop_tog;
         ok_meta <= burst_ok;
         ok_s <= ok_meta;
      end
   end

   assign burst_ok_s = ok_s;

   // system side
   always_comb begin
      next_burst_ok = word_program && !address_space_overlay;
      hf_ready = !host_valid || host_ready;
      next_host_valid = hf_ready ? hf_valid : host_valid;
      next_host_byte = (hf_ready && hf_valid) ? hf_data : host_byte;
      next_drop_pulse = drop_s ^ drop_old;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         burst_ok <= 1'b0;
         host_valid <= 1'b0;
         host_byte <= '0;
         drop_meta <= 1'b0;
         drop_s <= 1'b0;
         drop_old <= 1'b0;
         drop_pulse <= 1'b0;
      end else begin
         burst_ok <= next_burst_ok;
         host_valid <= next_host_valid;
         host_byte <= next_host_byte;
         drop_meta <= drop_tog;
         drop_s <= drop_meta;
         drop_old <= drop_s;
         drop_pulse <= next_drop_pulse;
      end
   end

   assign rd_pop = rf_ready && rf_valid;

   // link clock stops between frames, so mark the first edge instead
   sequence cs_opens;
      sel_fresh && !cs_n;
   endsequence

   sequence write_data;
      state == ST_XFER && !is_read;
   endsequence

   property fresh_p;
      @(posedge link_clk) disable iff (!rst_n)
         cs_opens |-> state == ST_CA && cnt == 4'h0;
   endproperty

   property strobe_low_p;
      @(posedge link_clk) disable iff (!rst_n || cs_n)
         write_data |-> rwds_oe && !rwds_out ##1 !rwds_out;
   endproperty

   chk_fresh_start: assert property (fresh_p)
      else $error("transaction did not restart on select");
   chk_write_strobe_low: assert property (strobe_low_p)
      else $error("strobe not held low during write");
   chk_write_no_drive: assert property (
      @(posedge link_clk) disable iff (!rst_n)
         write_data |-> !dq_oe)
      else $error("data bus driven during write");
   chk_release_deselect: assert property (
      @(posedge link_clk) disable iff (!rst_n)
         cs_n |-> !dq_oe && !rwds_oe && !rwds_out)
      else $error("pins still driven while deselected");
   chk_wrap_write_refused: assert property (
      @(posedge link_clk) disable iff (!rst_n || cs_n)
         write_data and !is_linear |-> !wf_valid && refused)
      else $error("wrapped write byte accepted");
   chk_single_word_only: assert property (
      @(posedge link_clk) disable iff (!rst_n || cs_n)
         write_data and cnt >= 4'(WORD_BYTES) && !burst_ok_s
            |-> !wf_valid)
      else $error("burst write accepted without program load");
   chk_strobe_on_data: assert property (
      @(posedge link_clk) disable iff (!rst_n || cs_n)
         !sel_fresh |-> $changed(rwds_tog) == $past(rd_pop))
      else $error("read strobe moved without new data");
endmodule

// File: verif/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
   // bus pins
   output logic ck,
   output logic ck_n,
   output logic delayed_host_clock,
   output logic delayed_host_clock_n,
   output logic cs_n,
   output logic [7:0] host_dq,
   // read side
   input wire logic [7:0] dq_out,
   input wire logic dq_oe,
   input wire logic rwds_out,
   input wire logic rwds_oe
);
   logic [7:0] cap[$];

   initial begin
      ck = 1'b0;
      cs_n = 1'b1;
      host_dq = 8'h5a;
   end
   assign ck_n = ~ck;
   // quarter period late, inside the data valid window
   assign #12 delayed_host_clock = ck;
   assign delayed_host_clock_n = ~delayed_host_clock;
   always @(rwds_out)
      if (cs_n === 1'b0 && rwds_oe === 1'b1 && dq_oe === 1'b1)
         cap.push_back(dq_out);

   // 48 ns period also meets the slow burst-write timing
   task automatic xfer(input logic [7:0] b0, input int n,
         input logic [7:0] d);
      cap.delete();
      cs_n = 1'b0;
      for (int i = 0; i < n + int'(b0[7]); i++) begin
         host_dq = i == 0 ? b0 : i < 6 ? 8'h00 : d + 8'(i - 6);
         #24 ck = 1'b1;
         #24 ck = 1'b0;
      end
      #2 cs_n = 1'b1;
      // released bus shows the complement of the last byte, not the byte itself
      host_dq = ~host_dq;
      #30;
   endtask

   // clock runs with select high while the bus carries a pattern
   task automatic idle(input int n);
      for (int i = 0; i < n; i++) begin
         host_dq = 8'h20 + 8'(i);
         #24 ck = 1'b1;
         #24 ck = 1'b0;
      end
      #30;
   endtask
endmodule

// File: verif/test_ddr_flash_bus_read_burst_write.sv
`timescale 1ns/1ps
module test_ddr_flash_bus_read_burst_write import flash_link_pkg::*;;
   // clocks and reset
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   // bus pins
   logic ck, ck_n, delayed_host_clock, delayed_host_clock_n, cs_n;
   logic [7:0] host_dq, dq_in, dq_out;
   logic dq_oe, rwds_in, rwds_out, rwds_oe;
   logic phase_shifted_strobe_mode = 1'b0;
   // user side
   link_byte_s host_byte;
   logic host_valid, rd_ready, drop_pulse;
   logic host_ready = 1'b1;
   logic rd_valid = 1'b0;
   logic [7:0] rd_byte = 8'h00;
   logic word_program = 1'b0;
   logic address_space_overlay = 1'b0;
   // bookkeeping
   link_byte_s rx[$];
   logic in_write = 1'b0;
   int num_errors = 0;
   int cmp_count = 0;
   int drops = 0;

   always #12.5 sys_clk = ~sys_clk;
   // nobody else drives the strobe, so the released pin rests low
   assign rwds_in = rwds_oe ? rwds_out : 1'b0;
   assign dq_in = dq_oe ? dq_out : host_dq;

   host_bus_model i_host (.ck, .ck_n, .delayed_host_clock,
      .delayed_host_clock_n, .cs_n, .host_dq, .dq_out, .dq_oe, .rwds_out,
      .rwds_oe);
   flash_link_slave #(.LOW_VOLTAGE(1'b1)) i_dut (.sys_clk, .rst_n, .ck,
      .ck_n, .delayed_host_clock, .delayed_host_clock_n, .cs_n, .dq_in,
      .dq_out, .dq_oe, .rwds_in, .rwds_out, .rwds_oe,
      .phase_shifted_strobe_mode, .host_byte, .host_valid, .host_ready,
      .rd_byte, .rd_valid, .rd_ready, .word_program,
      .address_space_overlay, .drop_pulse);

   // sampled mid-cycle, where the registered outputs have settled
   always @(negedge sys_clk) begin
      if (host_valid === 1'b1 && host_ready)
         rx.push_back(host_byte);
      if (drop_pulse === 1'b1)
         drops++;
   end
   always @(negedge ck)
      if (in_write)
         chk({14'h0, rwds_oe, rwds_out}, 16'h2);

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic drive(input logic wp, input logic ovl, input logic hr);
      @(posedge sys_clk);
      #2;
      word_program = wp;
      address_space_overlay = ovl;
      host_ready = hr;
   endtask

   // keep < 0: consumer stalled, only a bounded prefix may arrive
   task automatic run_wr(input string name, input logic [7:0] b0,
         input int n, input int keep, input logic drop);
      rx.delete();
      drops = 0;
      in_write = 1'b1;
      i_host.xfer(b0, n + 6, 8'h40);
      in_write = 1'b0;
      chk({14'h0, dq_oe, rwds_oe}, 16'h0);
      drive(word_program, address_space_overlay, 1'b1);
      repeat (60) @(posedge sys_clk);
      if (keep < 0)
         chk(16'(rx.size() >= FIFO_DEPTH && rx.size() < n + 6), 16'h1);
      else
         chk(16'(rx.size()), 16'(keep + 6));
      for (int i = 0; i < rx.size(); i++)
         chk({7'h0, rx[i]}, {7'h0, i < 6, i == 0 ? b0 : i < 6 ? 8'h00 :
            8'h40 + 8'(i - 6)});
      chk({15'h0, drops != 0}, {15'h0, drop});
      $display("test %s done", name);
   endtask

   task automatic fill(input int n, output int got);
      logic took;
      got = 0;
      @(posedge sys_clk);
      #2;
      rd_valid = 1'b1;
      for (int i = 0; i < n; i++) begin
         rd_byte = 8'h80 + 8'(got);
         took = rd_ready;
         @(posedge sys_clk);
         #2;
         if (took === 1'b1)
            got++;
      end
      rd_valid = 1'b0;
   endtask

   // clock runs with select high; nothing may reach the user side
   task automatic run_idle(input string name);
      rx.delete();
      drops = 0;
      i_host.idle(4);
      repeat (10) @(posedge sys_clk);
      chk(16'(rx.size()), 16'h0);
      chk({15'h0, drops != 0}, 16'h0);
      chk({14'h0, dq_oe, rwds_oe}, 16'h0);
      $display("test %s done", name);
   endtask

   task automatic run_rd(input string name, input int n, input int got);
      i_host.xfer(8'ha0, n + 12, 8'h00);
      chk({14'h0, dq_oe, rwds_oe}, 16'h0);
      chk(16'(i_host.cap.size()), 16'(got));
      for (int i = 0; i < i_host.cap.size(); i++)
         chk({8'h0, i_host.cap[i]}, {8'h0, 8'h80 + 8'(i)});
      $display("test %s done", name);
   endtask

   initial begin
      int got;
      repeat (3) @(posedge sys_clk);
      #2;
      rst_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      run_wr("single", 8'h20, 2, 2, 1'b0);
      run_idle("deselected");
      drive(1'b1, 1'b0, 1'b1);
      run_wr("burst", 8'h20, 6, 6, 1'b0);
      drive(1'b0, 1'b0, 1'b1);
      run_wr("no_program", 8'h20, 4, 2, 1'b1);
      drive(1'b1, 1'b1, 1'b1);
      run_wr("overlay", 8'h20, 4, 2, 1'b1);
      drive(1'b1, 1'b0, 1'b1);
      run_wr("wrapped", 8'h00, 2, 0, 1'b1);
      drive(1'b1, 1'b0, 1'b0);
      run_wr("overrun", 8'h20, 16, -1, 1'b1);
      run_rd("empty", 2, 0);
      fill(20, got);
      chk(16'(got), 16'(FIFO_DEPTH));
      run_rd("full", 16, 16);
      @(posedge sys_clk);
      #2;
      phase_shifted_strobe_mode = 1'b1;
      fill(3, got);
      chk(16'(got), 16'h3);
      run_rd("delayed", 3, 3);
      give_verdict;
   end

   initial begin
      #1000000;
      num_errors++;
      give_verdict;
   end
endmodule
